// *** inc/pwm_gen_consts.vh ***
// Overview of operation
// (RULE1) enable clear: generator idle, counter held at zero
// (RULE2) enable set: generator runs, outputs driven
// (RULE3) mode zero: count down, reload at zero
// (RULE4) mode one: up to load, down, repeat
// (RULE5) two independent outputs from one counter
// (RULE6) or complementary pair with dead-band delay
// (RULE7) generator zero drives pins a and b
// (RULE8) generator one drives pins c and d
// (RULE9) updates at zero, or after global sync
// (RULE10) debug clear: halt stops counter at zero
`ifndef PWM_GEN_CONSTS_VH
`define PWM_GEN_CONSTS_VH
`define ADDR_GEN0_CTL      12'h040
`define ADDR_GEN1_CTL      12'h080
`define ADDR_GEN0_LOAD     12'h050
`define ADDR_GEN0_CMPA     12'h058
`define ADDR_GEN0_CMPB     12'h05C
`define ADDR_GEN0_DBCTL    12'h060
`define ADDR_GEN0_DBRISE   12'h064
`define ADDR_GEN0_DBFALL   12'h068
`define ADDR_GEN0_COUNT    12'h054
`define ADDR_GEN_STRIDE    12'h040
`define ADDR_SYNC_UPDATE   12'h028
`define CTL_ENABLE         0
`define CTL_MODE           1
`define CTL_DEBUG          2
`define CTL_LOAD_UPD       3
`define CTL_CMPA_UPD       4
`define CTL_CMPB_UPD       5
`define CTL_WIDTH          6
`define CTL_RESET          6'h00
`define CNT_WIDTH          16
`define DB_WIDTH           12
`define VAL_RESET          16'h0000
`endif

// *** hw/pwm_gen_channel.v ***
`timescale 1ns/100ps
`include "pwm_gen_consts.vh"
module pwm_gen_channel (
    input  wire                   clk,
    input  wire                   rst,
    input  wire [`CTL_WIDTH-1:0]  ctl,
    input  wire [`CNT_WIDTH-1:0]  loadW,
    input  wire [`CNT_WIDTH-1:0]  cmpAW,
    input  wire [`CNT_WIDTH-1:0]  cmpBW,
    input  wire                   loadWr,
    input  wire                   cmpAWr,
    input  wire                   cmpBWr,
    input  wire                   syncReq,
    input  wire                   cpuHalted,
    input  wire                   dbEnable,
    input  wire [`DB_WIDTH-1:0]   dbRise,
    input  wire [`DB_WIDTH-1:0]   dbFall,
    output reg  [`CNT_WIDTH-1:0]  count_q,
    output reg                    outA_q,
    output reg                    outB_q
);
    reg [`CNT_WIDTH-1:0] load_q, cmpA_q, cmpB_q;
    reg [2:0]            pend_q;
    reg [2:0]            armed_q;
    reg                  dirUp_q;
    reg                  rawA_q, rawB_q;
    reg [`DB_WIDTH-1:0]  dbCnt_q;
    reg                  dbOut_q;
    wire                 run = ctl[`CTL_ENABLE];
    wire                 atZero = (count_q == `VAL_RESET);
    // (RULE10) halt stall at zero
    wire                 stall = cpuHalted & ~ctl[`CTL_DEBUG] & atZero;
    wire [2:0]           wrs = {cmpBWr, cmpAWr, loadWr};
    wire [2:0]           sel = {ctl[`CTL_CMPB_UPD], ctl[`CTL_CMPA_UPD], ctl[`CTL_LOAD_UPD]};
    // ----------------------------------------
    // update timing
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : upd
            // (RULE9) write applies at zero
            wire fire = pend_q[i] & atZero & (~sel[i] | armed_q[i] | syncReq);
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    pend_q[i]  <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (wrs[i]) begin
                    pend_q[i]  <= 1'b1;
                    armed_q[i] <= 1'b0;
                end else if (fire) begin
                    pend_q[i]  <= 1'b0;
                    armed_q[i] <= 1'b0;
                end else if (syncReq & pend_q[i]) begin
                    armed_q[i] <= 1'b1;
                end
            end
        end
    endgenerate
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            load_q <= `VAL_RESET;
            cmpA_q <= `VAL_RESET;
            cmpB_q <= `VAL_RESET;
        end else begin
            if (upd[0].fire) load_q <= loadW;
            if (upd[1].fire) cmpA_q <= cmpAW;
            if (upd[2].fire) cmpB_q <= cmpBW;
        end
    end
    // ----------------------------------------
    // counter
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= `VAL_RESET;
            dirUp_q <= 1'b1;
        // (RULE1) disabled holds idle
        end else if (!run) begin
            count_q <= `VAL_RESET;
            dirUp_q <= 1'b1;
        end else if (!stall) begin
            // (RULE4) up/down triangle
            if (ctl[`CTL_MODE]) begin
                if (dirUp_q) begin
                    if (count_q >= load_q) begin
                        dirUp_q <= 1'b0;
                        count_q <= (load_q == `VAL_RESET) ? `VAL_RESET : load_q - 16'h0001;
                    end else begin
                        count_q <= count_q + 16'h0001;
                    end
                end else if (count_q == `VAL_RESET) begin
                    dirUp_q <= 1'b1;
                    count_q <= (load_q == `VAL_RESET) ? `VAL_RESET : 16'h0001;
                end else begin
                    count_q <= count_q - 16'h0001;
                end
            // (RULE3) down with reload
            end else begin
                dirUp_q <= 1'b0;
                count_q <= atZero ? load_q : count_q - 16'h0001;
            end
        end
    end
    // ----------------------------------------
    // outputs and dead band
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rawA_q  <= 1'b0;
            rawB_q  <= 1'b0;
            dbCnt_q <= {`DB_WIDTH{1'b0}};
            dbOut_q <= 1'b0;
            outA_q  <= 1'b0;
            outB_q  <= 1'b0;
        end else if (!run) begin
            rawA_q  <= 1'b0;
            rawB_q  <= 1'b0;
            dbCnt_q <= {`DB_WIDTH{1'b0}};
            dbOut_q <= 1'b0;
            outA_q  <= 1'b0;
            outB_q  <= 1'b0;
        end else begin
            // (RULE5) independent compares
            if (atZero) rawA_q <= 1'b1;
            else if (count_q == cmpA_q) rawA_q <= 1'b0;
            if (atZero) rawB_q <= 1'b1;
            else if (count_q == cmpB_q) rawB_q <= 1'b0;
            if (rawA_q != dbOut_q) begin
                if (dbCnt_q >= (rawA_q ? dbRise : dbFall)) begin
                    dbOut_q <= rawA_q;
                    dbCnt_q <= {`DB_WIDTH{1'b0}};
                end else begin
                    dbCnt_q <= dbCnt_q + 12'h001;
                end
            end else begin
                dbCnt_q <= {`DB_WIDTH{1'b0}};
            end
            // (RULE6) paired dead-band outputs
            if (dbEnable) begin
                outA_q <= dbOut_q & rawA_q;
                outB_q <= ~dbOut_q & ~rawA_q;
            end else begin
                // (RULE2) enabled outputs driven
                outA_q <= rawA_q;
                outB_q <= rawB_q;
            end
        end
    end
endmodule

// *** hw/pwm_gen_top.v ***
`timescale 1ns/100ps
`include "pwm_gen_consts.vh"
module pwm_gen_top (
    input  wire        clk,
    input  wire        nrst,
    input  wire [11:0] addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    input  wire        cpuHalted,
    output reg  [31:0] rdata,
    output reg         outputPinA,
    output reg         outputPinB,
    output reg         outputPinC,
    output reg         outputPinD
);
    reg  rstS1_q, rstS2_q;
    wire rst = ~rstS2_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstS1_q <= 1'b0;
            rstS2_q <= 1'b0;
        end else begin
            rstS1_q <= 1'b1;
            rstS2_q <= rstS1_q;
        end
    end
    // ----------------------------------------
    // registers per generator
    // ----------------------------------------
    reg  [`CTL_WIDTH-1:0] ctl_q   [0:1];
    reg  [`CNT_WIDTH-1:0] load_q  [0:1];
    reg  [`CNT_WIDTH-1:0] cmpA_q  [0:1];
    reg  [`CNT_WIDTH-1:0] cmpB_q  [0:1];
    reg                   dbEn_q  [0:1];
    reg  [`DB_WIDTH-1:0]  dbRise_q[0:1];
    reg  [`DB_WIDTH-1:0]  dbFall_q[0:1];
    wire [`CNT_WIDTH-1:0] cnt     [0:1];
    wire [1:0]            pA, pB;
    wire                  syncWr = wr & (addr == `ADDR_SYNC_UPDATE);
    reg  [1:0]            syncReq_q;
    reg  [31:0]           rdata_d;
    always @(posedge clk or posedge rst) begin
        if (rst) syncReq_q <= 2'b00;
        else     syncReq_q <= syncWr ? wdata[1:0] : 2'b00;
    end
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen
            wire [11:0] base = (g == 0) ? 12'h000 : `ADDR_GEN_STRIDE;
            wire wCtl  = wr & (addr == `ADDR_GEN0_CTL + base);
            wire wLoad = wr & (addr == `ADDR_GEN0_LOAD + base);
            wire wCmpA = wr & (addr == `ADDR_GEN0_CMPA + base);
            wire wCmpB = wr & (addr == `ADDR_GEN0_CMPB + base);
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    ctl_q[g]    <= `CTL_RESET;
                    load_q[g]   <= `VAL_RESET;
                    cmpA_q[g]   <= `VAL_RESET;
                    cmpB_q[g]   <= `VAL_RESET;
                    dbEn_q[g]   <= 1'b0;
                    dbRise_q[g] <= {`DB_WIDTH{1'b0}};
                    dbFall_q[g] <= {`DB_WIDTH{1'b0}};
                end else begin
                    if (wCtl)  ctl_q[g]  <= wdata[`CTL_WIDTH-1:0];
                    if (wLoad) load_q[g] <= wdata[`CNT_WIDTH-1:0];
                    if (wCmpA) cmpA_q[g] <= wdata[`CNT_WIDTH-1:0];
                    if (wCmpB) cmpB_q[g] <= wdata[`CNT_WIDTH-1:0];
                    if (wr & (addr == `ADDR_GEN0_DBCTL + base))  dbEn_q[g]   <= wdata[0];
                    if (wr & (addr == `ADDR_GEN0_DBRISE + base)) dbRise_q[g] <= wdata[`DB_WIDTH-1:0];
                    if (wr & (addr == `ADDR_GEN0_DBFALL + base)) dbFall_q[g] <= wdata[`DB_WIDTH-1:0];
                end
            end
            pwm_gen_channel u_chan (
                .clk       (clk),
                .rst       (rst),
                .ctl       (ctl_q[g]),
                .loadW     (load_q[g]),
                .cmpAW     (cmpA_q[g]),
                .cmpBW     (cmpB_q[g]),
                .loadWr    (wLoad),
                .cmpAWr    (wCmpA),
                .cmpBWr    (wCmpB),
                .syncReq   (syncReq_q[g]),
                .cpuHalted (cpuHalted),
                .dbEnable  (dbEn_q[g]),
                .dbRise    (dbRise_q[g]),
                .dbFall    (dbFall_q[g]),
                .count_q   (cnt[g]),
                .outA_q    (pA[g]),
                .outB_q    (pB[g])
            );
        end
    endgenerate
    // ----------------------------------------
    // read mux and pins
    // ----------------------------------------
    always @* begin
        rdata_d = 32'h00000000;
        case (addr)
            `ADDR_GEN0_CTL:                      rdata_d[`CTL_WIDTH-1:0] = ctl_q[0];
            `ADDR_GEN1_CTL:                      rdata_d[`CTL_WIDTH-1:0] = ctl_q[1];
            `ADDR_GEN0_LOAD:                     rdata_d[15:0] = load_q[0];
            `ADDR_GEN0_LOAD + `ADDR_GEN_STRIDE:  rdata_d[15:0] = load_q[1];
            `ADDR_GEN0_COUNT:                    rdata_d[15:0] = cnt[0];
            `ADDR_GEN0_COUNT + `ADDR_GEN_STRIDE: rdata_d[15:0] = cnt[1];
            `ADDR_GEN0_CMPA:                     rdata_d[15:0] = cmpA_q[0];
            `ADDR_GEN0_CMPA + `ADDR_GEN_STRIDE:  rdata_d[15:0] = cmpA_q[1];
            `ADDR_GEN0_CMPB:                     rdata_d[15:0] = cmpB_q[0];
            `ADDR_GEN0_CMPB + `ADDR_GEN_STRIDE:  rdata_d[15:0] = cmpB_q[1];
            default:                             rdata_d = 32'h00000000;
        endcase
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata      <= 32'h00000000;
            outputPinA <= 1'b0;
            outputPinB <= 1'b0;
            outputPinC <= 1'b0;
            outputPinD <= 1'b0;
        end else begin
            rdata <= rd ? rdata_d : 32'h00000000;
            // (RULE7) generator zero pins
            outputPinA <= pA[0];
            outputPinB <= pB[0];
            // (RULE8) generator one pins
            outputPinC <= pA[1];
            outputPinD <= pB[1];
        end
    end
endmodule

// *** tb/pwm_gen_top_properties.sv ***
`timescale 1ns/100ps
module pwm_gen_top_properties (
    input logic        clk,
    input logic        nrst,
    input logic [11:0] addr,
    input logic [31:0] wdata,
    input logic        wr,
    input logic        rd,
    input logic        cpuHalted,
    input logic [31:0] rdata,
    input logic        outputPinA,
    input logic        outputPinB,
    input logic        outputPinC,
    input logic        outputPinD
);
    // ----------
    // control shadows and idle counters
    // ----------
    logic [5:0] ctl0_q, ctl1_q;
    logic [2:0] off0_q, off1_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl0_q <= 6'h00;
            ctl1_q <= 6'h00;
            off0_q <= 3'h0;
            off1_q <= 3'h0;
        end else begin
            if (wr && addr == 12'h040) ctl0_q <= wdata[5:0];
            if (wr && addr == 12'h080) ctl1_q <= wdata[5:0];
            off0_q <= ctl0_q[0] ? 3'h0 : (off0_q == 3'h7 ? 3'h7 : off0_q + 3'h1);
            off1_q <= ctl1_q[0] ? 3'h0 : (off1_q == 3'h7 ? 3'h7 : off1_q + 3'h1);
        end
    end
    // ----------
    // properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_cnt0;
        rd && addr == 12'h054 && ctl0_q[1:0] == 2'b01 && !cpuHalted;
    endsequence
    sequence s_cnt1;
        rd && addr == 12'h094 && ctl1_q[1:0] == 2'b11;
    endsequence
    sequence s_halt0;
        rd && addr == 12'h054 && cpuHalted && ctl0_q[2:0] == 3'b001;
    endsequence
    property p_ctl0Back;
        logic [5:0] v;
        (wr && addr == 12'h040, v = wdata[5:0]) ##[1:2] (rd && addr == 12'h040) |=> rdata == {26'h0000000, v};
    endproperty
    property p_down;
        logic [15:0] v;
        s_cnt0 ##1 (s_cnt0 and (rdata[15:0] != 16'h0000, v = rdata[15:0])) |=> rdata[15:0] == v - 16'h0001;
    endproperty
    property p_upDown;
        logic [15:0] v;
        s_cnt1 ##1 (s_cnt1, v = rdata[15:0]) |=> rdata[15:0] == v + 16'h0001 || rdata[15:0] == v - 16'h0001;
    endproperty
    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
        else $error("read data not zero outside read answer");
    chk_ctl0_readback: assert property (p_ctl0Back)
        else $error("control zero readback wrong");
    chk_ctl1_readback: assert property (rd && addr == 12'h080 |=> rdata == {26'h0000000, ctl1_q})
        else $error("control one readback wrong");
    chk_unmapped_read: assert property (rd && addr == 12'h0FC |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_gen0_off: assert property (off0_q == 3'h7 |-> !outputPinA && !outputPinB)
        else $error("generator zero pins active while disabled");
    chk_gen1_off: assert property (off1_q == 3'h7 |-> {outputPinC, outputPinD} == 2'b00)
        else $error("generator one pins active while disabled");
    chk_down_step: assert property (p_down)
        else $error("down count step wrong");
    chk_updown_step: assert property (p_upDown)
        else $error("up down count step wrong");
    chk_halt_hold: assert property (s_halt0 ##1 (s_halt0 and rdata[15:0] == 16'h0000) |=> rdata == 32'h00000000)
        else $error("counter left zero while halted");
endmodule
bind pwm_gen_top pwm_gen_top_properties u_props (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .cpuHalted(cpuHalted), .rdata(rdata), .outputPinA(outputPinA), .outputPinB(outputPinB),
    .outputPinC(outputPinC), .outputPinD(outputPinD));

// *** tb/pwm_generator_control_tb_top.sv ***
`timescale 1ns/100ps
module pwm_generator_control_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        cpuHalted = 1'b0;
    logic [31:0] rdata;
    logic        outputPinA, outputPinB, outputPinC, outputPinD;
    logic [31:0] vals [0:15];
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;
    int          hi [4];
    int          bothAB, diffAB;
    always #20 clk = ~clk;
    pwm_gen_top dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .cpuHalted(cpuHalted),
        .rdata(rdata), .outputPinA(outputPinA), .outputPinB(outputPinB), .outputPinC(outputPinC),
        .outputPinD(outputPinD));
    // ----------
    // tasks
    // ----------
    task automatic end_of_test;
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdBurst(input logic [11:0] a, input int n);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            if (k == n - 1) rd <= 1'b0;
            @(negedge clk);
            vals[k] = rdata;
        end
    endtask
    task automatic watch(input int n);
        hi = '{0, 0, 0, 0};
        bothAB = 0;
        diffAB = 0;
        repeat (n) begin
            @(negedge clk);
            hi[0] += outputPinA;
            hi[1] += outputPinB;
            hi[2] += outputPinC;
            hi[3] += outputPinD;
            bothAB += outputPinA & outputPinB;
            diffAB += outputPinA ^ outputPinB;
        end
    endtask
    // sixteen back-to-back count reads, checked step by step
    task automatic scan(input logic [11:0] a, input logic upDown, input logic [15:0] load);
        int bad;
        logic [15:0] mx, p, c;
        bad = 0;
        mx = 16'h0000;
        rdBurst(a, 16);
        for (int k = 1; k < 16; k++) begin
            p = vals[k-1][15:0];
            c = vals[k][15:0];
            if (upDown ? (c != p + 16'h0001 && c != p - 16'h0001) : (p == 16'h0000 ? c != load : c != p - 16'h0001))
                bad++;
            if (c > mx) mx = c;
        end
        chk("count steps", 32'h00000000, bad);
        chk("count peak", {16'h0000, load}, {16'h0000, mx});
    endtask
    // ----------
    // hang guard and main sequence
    // ----------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdBurst(12'h040, 1);
        chk("ctl0 reset", 32'h00000000, vals[0]);
        wrReg(12'h080, 32'hFFFFFFFF);
        rdBurst(12'h080, 1);
        chk("ctl1 width", 32'h0000003F, vals[0]);
        wrReg(12'h080, 32'h00000000);
        rdBurst(12'h0FC, 1);
        chk("unmapped", 32'h00000000, vals[0]);
        wrReg(12'h050, 32'h00000009);
        wrReg(12'h058, 32'h00000004);
        wrReg(12'h05C, 32'h00000006);
        watch(20);
        chk("pins idle", 32'h00000000, hi[0] + hi[1]);
        wrReg(12'h040, 32'h00000001);
        repeat (30) @(posedge clk);
        scan(12'h054, 1'b0, 16'h0009);
        watch(40);
        chk("pinA toggles", 32'h00000001, hi[0] > 0 && hi[0] < 40);
        chk("pins differ", 32'h00000001, diffAB > 0);
        chk("gen1 quiet", 32'h00000000, hi[2] + hi[3]);
        wrReg(12'h090, 32'h00000005);
        wrReg(12'h098, 32'h00000002);
        wrReg(12'h080, 32'h00000003);
        repeat (30) @(posedge clk);
        scan(12'h094, 1'b1, 16'h0005);
        watch(40);
        chk("pinC toggles", 32'h00000001, hi[2] > 0 && hi[2] < 40);
        wrReg(12'h060, 32'h00000001);
        wrReg(12'h064, 32'h00000002);
        wrReg(12'h068, 32'h00000002);
        watch(40);
        chk("pair overlap", 32'h00000000, bothAB);
        chk("pair toggles", 32'h00000001, hi[0] > 0 && hi[0] < 40);
        @(posedge clk);
        cpuHalted <= 1'b1;
        repeat (20) @(posedge clk);
        rdBurst(12'h054, 3);
        chk("halted count", 32'h00000000, vals[0] | vals[2]);
        @(posedge clk);
        cpuHalted <= 1'b0;
        scan(12'h054, 1'b0, 16'h0009);
        wrReg(12'h040, 32'h00000005);
        @(posedge clk);
        cpuHalted <= 1'b1;
        scan(12'h054, 1'b0, 16'h0009);
        @(posedge clk);
        cpuHalted <= 1'b0;
        wrReg(12'h040, 32'h00000009);
        rdBurst(12'h040, 1);
        chk("ctl0 readback", 32'h00000009, vals[0]);
        wrReg(12'h050, 32'h00000003);
        repeat (30) @(posedge clk);
        scan(12'h054, 1'b0, 16'h0009);
        wrReg(12'h028, 32'h00000001);
        repeat (30) @(posedge clk);
        scan(12'h054, 1'b0, 16'h0003);
        wrReg(12'h040, 32'h00000001);
        wrReg(12'h050, 32'h00000009);
        repeat (30) @(posedge clk);
        scan(12'h054, 1'b0, 16'h0009);
        wrReg(12'h040, 32'h00000000);
        repeat (10) @(posedge clk);
        watch(20);
        chk("pins off", 32'h00000000, hi[0] + hi[1]);
        end_of_test;
    end
endmodule
